/* File: rtl/rate_converter_filter_and_clock_select.sv */
`timescale 1ns/100ps
`default_nettype none
module rate_converter_filter_and_clock_select (
  input  wire logic                          I_CLK_SYS,
  input  wire logic                          I_RST_N,
  input  wire logic                          I_WB_CYC,
  input  wire logic                          I_WB_STB,
  input  wire logic                          I_WB_WE,
  input  wire logic [7:0]                    I_WB_ADR,
  input  wire logic [3:0]                    I_WB_SEL,
  input  wire logic [31:0]                   I_WB_DAT,
  output var  logic [31:0]                   O_WB_DAT,
  output var  logic                          O_WB_ACK,
  input  wire logic [2:0]                    I_HW_MODE_VALID,
  input  wire conv_cfg_pkg::pair_modes_type  I_HW_MODE,
  output var  conv_cfg_pkg::pair_modes_type  O_MODE,
  output var  logic [2:0]                    O_POST_ACTIVE,
  output var  logic [2:0]                    O_AUTO_SELECT,
  output var  conv_cfg_pkg::clk_srcs_type    O_OUT_CLK_SRC,
  output var  conv_cfg_pkg::clk_srcs_type    O_IN_CLK_SRC
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_idx(input logic [7:0] adr, input logic [5:0] idx);
    is_idx = (adr[7:2] == idx) && (adr[1:0] == 2'h0);
  endfunction : is_idx

  function automatic logic [23:0] merge_bytes(input logic [23:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0]  sel);
    logic [23:0] res;
    res = old;
    for (int b = 0; b < 3; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    merge_bytes = res;
  endfunction : merge_bytes

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  conv_cfg_pkg::bus_state_type  state_ff;
  conv_cfg_pkg::bus_state_type  nxt_state;
  conv_cfg_pkg::pair_modes_type mode_ff;
  logic [2:0]                   auto_ff;
  logic [23:0]                  csr_ff;
  logic [23:0]                  fcfg_rd;
  logic [23:0]                  nxt_fcfg;
  logic [23:0]                  nxt_csr;
  logic [2:0]                   nxt_auto;
  logic [31:0]                  rd_word;
  logic                         req;
  logic                         wr_now;
  logic                         wr_ctrl;
  logic                         wr_fcfg;
  logic                         wr_csr;
  conv_cfg_pkg::clk_srcs_type   out_src;
  conv_cfg_pkg::clk_srcs_type   in_src;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  assign req     = I_WB_CYC && I_WB_STB;
  assign wr_now  = (state_ff == conv_cfg_pkg::ST_ACK) && req && I_WB_WE;
  assign wr_ctrl = wr_now && is_idx(I_WB_ADR, conv_cfg_pkg::IDX_CTRL);
  assign wr_fcfg = wr_now && is_idx(I_WB_ADR, conv_cfg_pkg::IDX_FCFG);
  assign wr_csr  = wr_now && is_idx(I_WB_ADR, conv_cfg_pkg::IDX_CSR); // RULE10

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      conv_cfg_pkg::ST_IDLE: begin
        if (req) begin
          nxt_state = conv_cfg_pkg::ST_ACK;
        end
      end
      conv_cfg_pkg::ST_ACK: begin
        nxt_state = conv_cfg_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = conv_cfg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_ff <= conv_cfg_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_WB_ACK <= 1'b0;
    end else begin
      O_WB_ACK <= (state_ff == conv_cfg_pkg::ST_IDLE) && req;
    end
  end

  // Read mux, reserved and unmapped bits are zero
  always_comb begin
    fcfg_rd = '0; // RULE18
    for (int p = 0; p < 3; p++) begin
      fcfg_rd[conv_cfg_pkg::FCFG_PRE_LSB + p*conv_cfg_pkg::FCFG_STRIDE +: 2] =
        mode_ff[p].pre; // RULE19
      fcfg_rd[conv_cfg_pkg::FCFG_POST_LSB + p*conv_cfg_pkg::FCFG_STRIDE +: 2] =
        mode_ff[p].post;
    end
    rd_word = '0;
    if (is_idx(I_WB_ADR, conv_cfg_pkg::IDX_CTRL)) begin
      rd_word[conv_cfg_pkg::CTRL_AUTO_LSB +: 3] = auto_ff;
    end else if (is_idx(I_WB_ADR, conv_cfg_pkg::IDX_FCFG)) begin
      rd_word[23:0] = fcfg_rd;
    end else if (is_idx(I_WB_ADR, conv_cfg_pkg::IDX_CSR)) begin
      rd_word[23:0] = csr_ff; // RULE10
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_WB_DAT <= 32'h00000000;
    end else if ((state_ff == conv_cfg_pkg::ST_IDLE) && req) begin
      O_WB_DAT <= I_WB_WE ? 32'h00000000 : rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and clock source registers

  assign nxt_fcfg = merge_bytes(fcfg_rd, I_WB_DAT, I_WB_SEL);
  assign nxt_csr  = merge_bytes(csr_ff, I_WB_DAT, I_WB_SEL);
  assign nxt_auto = I_WB_SEL[0] ? I_WB_DAT[conv_cfg_pkg::CTRL_AUTO_LSB +: 3] : auto_ff;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      auto_ff <= conv_cfg_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      auto_ff <= nxt_auto;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      csr_ff <= conv_cfg_pkg::CSR_RESET; // RULE10
    end else if (wr_csr) begin
      csr_ff <= nxt_csr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per pair mode fields and clock selection

  for (genvar p = 0; p < 3; p++) begin : g_pair
    localparam int PRE_LSB  = conv_cfg_pkg::FCFG_PRE_LSB + p*conv_cfg_pkg::FCFG_STRIDE;
    localparam int POST_LSB = conv_cfg_pkg::FCFG_POST_LSB + p*conv_cfg_pkg::FCFG_STRIDE;
    localparam int OUT_LSB  = conv_cfg_pkg::CSR_OUT_LSB + p*conv_cfg_pkg::CSR_STRIDE;
    localparam int IN_LSB   = conv_cfg_pkg::CSR_IN_LSB + p*conv_cfg_pkg::CSR_STRIDE;

    // Hardware update under auto select wins over a same-cycle software write
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
        mode_ff[p] <= conv_cfg_pkg::FCFG_RESET[3:0];
      end else if (auto_ff[p] && I_HW_MODE_VALID[p]) begin
        mode_ff[p] <= I_HW_MODE[p]; // RULE3 RULE4 RULE6 RULE8 RULE17 RULE19
      end else if (wr_fcfg) begin
        mode_ff[p].pre  <= nxt_fcfg[PRE_LSB +: 2]; // RULE1 RULE5 RULE7 RULE8
        mode_ff[p].post <= nxt_fcfg[POST_LSB +: 2]; // RULE4 RULE6 RULE17
      end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
        O_POST_ACTIVE[p] <= 1'b1;
      end else begin
        O_POST_ACTIVE[p] <= (mode_ff[p].pre != conv_cfg_pkg::MODE_PASS); // RULE2 RULE5 RULE7
      end
    end

    clk_src_decode #(
      .RSV_TOP_IS_AUX (1'b0)
    ) u_out_dec (
      .i_sel (csr_ff[OUT_LSB +: 4]), // RULE11 RULE12 RULE13
      .o_src (out_src[p])
    );

    clk_src_decode #(
      .RSV_TOP_IS_AUX (1'b1)
    ) u_in_dec (
      .i_sel (csr_ff[IN_LSB +: 4]), // RULE14 RULE15
      .o_src (in_src[p])
    );

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
        O_OUT_CLK_SRC[p] <= conv_cfg_pkg::clk_src_type'(6'h01);
        O_IN_CLK_SRC[p]  <= conv_cfg_pkg::clk_src_type'(6'h01);
      end else begin
        O_OUT_CLK_SRC[p] <= out_src[p];
        O_IN_CLK_SRC[p]  <= in_src[p];
      end
    end

    property p_pass_kills_post;
      @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      (mode_ff[p].pre == conv_cfg_pkg::MODE_PASS) |=> !O_POST_ACTIVE[p];
    endproperty
    a_pass_kills_post: assert property (p_pass_kills_post) // RULE2
      else $error("post filter active during passthrough");
  end

  always_comb begin
    O_MODE = mode_ff;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_AUTO_SELECT <= conv_cfg_pkg::CTRL_RESET;
    end else begin
      O_AUTO_SELECT <= auto_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_new_req;
    (state_ff == conv_cfg_pkg::ST_IDLE) && req;
  endsequence
  sequence s_ack_once;
    O_WB_ACK ##1 !O_WB_ACK;
  endsequence

  property p_ack_pulse;
    s_new_req |=> s_ack_once;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) // RULE10
    else $error("ack not a single pulse after request");

  property p_sw_pre_c;
    wr_fcfg && I_WB_SEL[1] && !(auto_ff[2] && I_HW_MODE_VALID[2])
      |=> O_MODE[2].pre == $past(I_WB_DAT[15:14]);
  endproperty
  a_sw_pre_c: assert property (p_sw_pre_c) // RULE1
    else $error("pair C pre field write lost");

  property p_hw_pre_c;
    auto_ff[2] && I_HW_MODE_VALID[2] |=> O_MODE[2] == $past(I_HW_MODE[2]);
  endproperty
  a_hw_pre_c: assert property (p_hw_pre_c) // RULE3
    else $error("pair C hardware update lost");

  property p_sw_post_b;
    wr_fcfg && I_WB_SEL[1] && !(auto_ff[1] && I_HW_MODE_VALID[1])
      |=> O_MODE[1].post == $past(I_WB_DAT[13:12]);
  endproperty
  a_sw_post_b: assert property (p_sw_post_b) // RULE4
    else $error("pair B post field write lost");

  property p_hw_post_a;
    auto_ff[0] && I_HW_MODE_VALID[0] |=> O_MODE[0].post == $past(I_HW_MODE[0].post);
  endproperty
  a_hw_post_a: assert property (p_hw_post_a) // RULE6
    else $error("pair A post hardware update lost");

  property p_no_hw_when_manual_a;
    !auto_ff[0] && I_HW_MODE_VALID[0] && !wr_fcfg |=> $stable(O_MODE[0]);
  endproperty
  a_no_hw_when_manual_a: assert property (p_no_hw_when_manual_a) // RULE8
    else $error("pair A changed without auto select");

  property p_fcfg_rsv_zero;
    s_new_req ##0 (!I_WB_WE && is_idx(I_WB_ADR, conv_cfg_pkg::IDX_FCFG))
      |=> O_WB_DAT[5:0] == 6'h00 && O_WB_DAT[31:18] == 14'h0000;
  endproperty
  a_fcfg_rsv_zero: assert property (p_fcfg_rsv_zero) // RULE18
    else $error("reserved filter bits read nonzero");

  property p_out_b_spdif;
    csr_ff[19:16] == conv_cfg_pkg::CS_SPDIF
      |=> O_OUT_CLK_SRC[1] == conv_cfg_pkg::clk_src_type'(6'h10);
  endproperty
  a_out_b_spdif: assert property (p_out_b_spdif) // RULE11
    else $error("pair B out S/PDIF not selected");

  property p_out_c_rsv;
    csr_ff[23:20] == 4'h6 |=> O_OUT_CLK_SRC[2] == conv_cfg_pkg::clk_src_type'(6'h00);
  endproperty
  a_out_c_rsv: assert property (p_out_c_rsv) // RULE13
    else $error("pair C reserved out code selected a clock");

  property p_in_c_aux;
    csr_ff[11:8] == 4'h7 |=> O_IN_CLK_SRC[2] == conv_cfg_pkg::clk_src_type'(6'h20);
  endproperty
  a_in_c_aux: assert property (p_in_c_aux) // RULE14
    else $error("pair C in code 0111 not aux");

endmodule : rate_converter_filter_and_clock_select
`default_nettype wire

/* File: rtl/conv_cfg_pkg.sv */
// What this block does
// [RULE1] Pair C pre-filter field bits 15-14: up2, direct, down2, passthrough.
// [RULE2] Pair C passthrough makes the pair C post-filter setting inactive.
// [RULE3] Pair C pre field is software owned; hardware updates it when auto is on.
// [RULE4] Pair B post field bits 13-12: up2, direct, down2; hardware owned under auto.
// [RULE5] Pair B pre field bits 11-10, same codes; passthrough disables pair B post.
// [RULE6] Pair A post field bits 9-8: up2, direct, down2; hardware owned under auto.
// [RULE7] Pair A pre field bits 7-6, passthrough makes pair A post inapplicable.
// [RULE8] Pair A pre field is user read/write; auto select lets hardware update it.
// [RULE9] Software writes zeros to filter config bits 5-0.
// [RULE10] Clock source register: 24 bits, read/write, index 0x5, resets to zero.
// [RULE11] Pair B out selector bits 19-16: ports 0-3, S/PDIF 0100, 0101-0111 reserved, 1000-1111 aux.
// [RULE12] Pair A out selector bits 15-12 uses the same out mapping.
// [RULE13] Pair C out selector bits 23-20, same mapping, S/PDIF at 0100.
// [RULE14] Pair C in selector bits 11-8: ports 0-3, S/PDIF 0100, 0101-0110 reserved.
// [RULE15] Pair B bits 7-4 and pair A bits 3-0 use the same in mapping.
// [RULE16] The aux clock comes from the system PLL, rate set elsewhere.
// [RULE17] Pair C post field bits 17-16: up2, direct, down2; hardware owned under auto.
// [RULE18] Reserved bits read zero and writes to them have no effect.
// [RULE19] Readback always shows the mode in effect, after hardware overwrite.
package conv_cfg_pkg;

  localparam int             NUM_PAIRS    = 3;
  localparam int             REG_W        = 24;
  localparam int             WB_ADR_W     = 8;
  localparam int             WB_DAT_W     = 32;
  localparam int             IDX_W        = 6;

  // Register indices, byte address is four times the index
  localparam logic [5:0]     IDX_CTRL     = 6'h00;
  localparam logic [5:0]     IDX_FCFG     = 6'h04;
  localparam logic [5:0]     IDX_CSR      = 6'h05;

  // Control register fields
  localparam int             CTRL_AUTO_LSB = 0;
  localparam logic [2:0]     CTRL_RESET    = 3'h0;

  // Filter config field layout, pair p at LSB + p * STRIDE
  localparam int             FCFG_PRE_LSB  = 6;
  localparam int             FCFG_POST_LSB = 8;
  localparam int             FCFG_STRIDE   = 4;
  localparam logic [23:0]    FCFG_RESET    = 24'h000000;

  // Clock source field layout
  localparam int             CSR_IN_LSB    = 0;
  localparam int             CSR_OUT_LSB   = 12;
  localparam int             CSR_STRIDE    = 4;
  localparam logic [23:0]    CSR_RESET     = 24'h000000;

  // Clock source codes and one-hot source positions
  localparam logic [3:0]     CS_SPDIF      = 4'h4;
  localparam logic [3:0]     CS_RSV_TOP    = 4'h7;
  localparam logic [3:0]     CS_AUX_MIN    = 4'h8;
  localparam int             SRC_W         = 6;
  localparam int             SRC_SPDIF_BIT = 4;
  localparam int             SRC_AUX_BIT   = 5;

  typedef enum logic [1:0] {
    MODE_UP2    = 2'h0,
    MODE_DIRECT = 2'h1,
    MODE_DOWN2  = 2'h2,
    MODE_PASS   = 2'h3
  } filt_mode_type;

  typedef struct packed {
    logic [1:0] pre;
    logic [1:0] post;
  } pair_mode_type;

  typedef pair_mode_type [2:0] pair_modes_type;
  typedef logic [SRC_W-1:0]    clk_src_type;
  typedef clk_src_type [2:0]   clk_srcs_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } bus_state_type;

endpackage : conv_cfg_pkg

/* File: rtl/clk_src_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module clk_src_decode #(
  parameter bit RSV_TOP_IS_AUX = 1'b0
) (
  input  wire logic [3:0]                i_sel,
  output var  conv_cfg_pkg::clk_src_type o_src
);

  always_comb begin
    o_src = '0;
    if (i_sel[3:2] == 2'h0) begin
      o_src[i_sel[1:0]] = 1'b1;
    end else if (i_sel == conv_cfg_pkg::CS_SPDIF) begin
      o_src[conv_cfg_pkg::SRC_SPDIF_BIT] = 1'b1;
    end else if (i_sel >= conv_cfg_pkg::CS_AUX_MIN) begin
      o_src[conv_cfg_pkg::SRC_AUX_BIT] = 1'b1; // RULE16
    end else if (RSV_TOP_IS_AUX && (i_sel == conv_cfg_pkg::CS_RSV_TOP)) begin
      o_src[conv_cfg_pkg::SRC_AUX_BIT] = 1'b1; // RULE15
    end
  end

endmodule : clk_src_decode
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                           I_CLK_SYS;
  logic                           I_RST_N;
  logic                           I_WB_CYC;
  logic                           I_WB_STB;
  logic                           I_WB_WE;
  logic [7:0]                     I_WB_ADR;
  logic [3:0]                     I_WB_SEL;
  logic [31:0]                    I_WB_DAT;
  logic [31:0]                    O_WB_DAT;
  logic                           O_WB_ACK;
  logic [2:0]                     I_HW_MODE_VALID;
  conv_cfg_pkg::pair_modes_type   I_HW_MODE;
  conv_cfg_pkg::pair_modes_type   O_MODE;
  logic [2:0]                     O_POST_ACTIVE;
  logic [2:0]                     O_AUTO_SELECT;
  conv_cfg_pkg::clk_srcs_type     O_OUT_CLK_SRC;
  conv_cfg_pkg::clk_srcs_type     O_IN_CLK_SRC;
  int                             err_count;
  int                             checked;
  logic [23:0]                    fcfg;
  logic [23:0]                    csr;
  logic [31:0]                    rd;
  logic [31:0]                    wd;
  logic [3:0]                     sl;

  rate_converter_filter_and_clock_select i_rate_converter_filter_and_clock_select (
    .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
    .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
    .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_HW_MODE_VALID(I_HW_MODE_VALID),
    .I_HW_MODE(I_HW_MODE), .O_MODE(O_MODE), .O_POST_ACTIVE(O_POST_ACTIVE),
    .O_AUTO_SELECT(O_AUTO_SELECT), .O_OUT_CLK_SRC(O_OUT_CLK_SRC), .O_IN_CLK_SRC(O_IN_CLK_SRC));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    I_CLK_SYS = 1'b0;
    forever #10 I_CLK_SYS = ~I_CLK_SYS;
  end

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk

  // One classic Wishbone cycle, released after ack is seen or after 20 cycles
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge I_CLK_SYS);
    I_WB_CYC <= 1'b1;
    I_WB_STB <= 1'b1;
    I_WB_WE  <= we;
    I_WB_ADR <= adr;
    I_WB_SEL <= sel;
    I_WB_DAT <= dat;
    do begin
      @(posedge I_CLK_SYS);
      n++;
    end while (O_WB_ACK !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    rdat = O_WB_DAT;
    I_WB_CYC <= 1'b0;
    I_WB_STB <= 1'b0;
    I_WB_WE  <= 1'b0;
  endtask : wb

  function automatic logic [23:0] merge(logic [23:0] old, logic [31:0] d, logic [3:0] s,
                                        logic [23:0] msk);
    for (int b = 0; b < 3; b++) if (s[b]) old[8*b +: 8] = d[8*b +: 8];
    return old & msk;
  endfunction : merge

  function automatic conv_cfg_pkg::pair_modes_type modes_of(logic [23:0] f);
    conv_cfg_pkg::pair_modes_type m;
    for (int p = 0; p < 3; p++) m[p] = {f[6+4*p +: 2], f[8+4*p +: 2]};
    return m;
  endfunction : modes_of

  function automatic logic [2:0] post_of(logic [23:0] f);
    logic [2:0] a;
    for (int p = 0; p < 3; p++) a[p] = (f[6+4*p +: 2] != 2'h3);
    return a;
  endfunction : post_of

  function automatic conv_cfg_pkg::clk_src_type src_of(logic [3:0] c, bit is_in);
    if (c < 4'h4) return 6'h01 << c;
    if (c == 4'h4) return 6'h10;
    if (c == 4'h7 && is_in) return 6'h20;
    if (c < 4'h8) return 6'h00;
    return 6'h20;
  endfunction : src_of

  task automatic chk_modes;
    repeat (2) @(posedge I_CLK_SYS);
    #1;
    chk(modes_of(fcfg), O_MODE);
    chk(post_of(fcfg), O_POST_ACTIVE);
  endtask : chk_modes

  initial begin
    repeat (20000) @(posedge I_CLK_SYS);
    err_count++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    I_RST_N = 1'b0;
    I_WB_CYC = 1'b0;
    I_WB_STB = 1'b0;
    I_WB_WE = 1'b0;
    I_WB_ADR = 8'h00;
    I_WB_SEL = 4'h0;
    I_WB_DAT = 32'h00000000;
    I_HW_MODE_VALID = 3'h0;
    I_HW_MODE = '0;
    err_count = 0;
    checked = 0;
    fcfg = 24'h000000;
    csr = 24'h000000;
    void'($urandom(12156));
    repeat (5) @(posedge I_CLK_SYS);
    I_RST_N <= 1'b1;
    // Reset values
    #1;
    for (int p = 0; p < 3; p++) chk(6'h01, O_IN_CLK_SRC[p]);
    wb(1'b0, 8'h14, 32'h0, 4'hf, rd); chk(32'h0, rd);
    wb(1'b0, 8'h10, 32'h0, 4'hf, rd); chk(32'h0, rd);
    // Every selector code in every field
    for (int c = 0; c < 16; c++) begin
      csr = {6{c[3:0]}};
      wb(1'b1, 8'h14, {8'hff, csr}, 4'hf, rd);
      wb(1'b0, 8'h14, 32'h0, 4'hf, rd); chk({8'h00, csr}, rd);
      #1;
      for (int p = 0; p < 3; p++) begin
        chk(src_of(c[3:0], 1'b0), O_OUT_CLK_SRC[p]);
        chk(src_of(c[3:0], 1'b1), O_IN_CLK_SRC[p]);
      end
    end
    // All filter fields set to passthrough at once, reserved bits 31-18 written as ones, bits 5-0 as zeros
    wb(1'b1, 8'h10, 32'hffffffc0, 4'hf, rd);
    fcfg = 24'h03ffc0;
    wb(1'b0, 8'h10, 32'h0, 4'hf, rd); chk({8'h00, fcfg}, rd);
    chk_modes();
    // Random writes with random byte lanes, software owned modes
    for (int i = 0; i < 60; i++) begin
      wd = $urandom();
      sl = 4'($urandom_range(15, 1));
      if (i[0]) begin
        wd[5:0] = 6'h00;
        fcfg = merge(fcfg, wd, sl, 24'h03ffc0);
        wb(1'b1, 8'h10, wd, sl, rd);
        wb(1'b0, 8'h10, 32'h0, 4'hf, rd); chk({8'h00, fcfg}, rd);
        chk_modes();
      end else begin
        csr = merge(csr, wd, sl, 24'hffffff);
        wb(1'b1, 8'h14, wd, sl, rd);
        wb(1'b0, 8'h14, 32'h0, 4'hf, rd); chk({8'h00, csr}, rd);
      end
    end
    // Unmapped and misaligned places
    wb(1'b1, 8'h08, 32'hffffffff, 4'hf, rd);
    wb(1'b0, 8'h08, 32'h0, 4'hf, rd); chk(32'h0, rd);
    wb(1'b1, 8'h16, 32'hffffffff, 4'hf, rd);
    wb(1'b0, 8'h15, 32'h0, 4'hf, rd); chk(32'h0, rd);
    wb(1'b0, 8'h14, 32'h0, 4'hf, rd); chk({8'h00, csr}, rd);
    // Hardware updates with auto on for pairs A and C, then for pair B only
    for (int k = 0; k < 2; k++) begin
      sl = k ? 4'h2 : 4'h5;
      wb(1'b1, 8'h00, {28'h0000000, sl}, 4'h1, rd);
      repeat (2) @(posedge I_CLK_SYS);
      #1;
      chk(sl[2:0], O_AUTO_SELECT);
      for (int i = 0; i < 6; i++) begin
        @(posedge I_CLK_SYS);
        wd = $urandom();
        I_HW_MODE <= wd[11:0];
        I_HW_MODE_VALID <= 3'h7;
        @(posedge I_CLK_SYS);
        I_HW_MODE_VALID <= 3'h0;
        for (int p = 0; p < 3; p++) begin
          if (sl[p]) fcfg[6+4*p +: 4] = {I_HW_MODE[p][1:0], I_HW_MODE[p][3:2]};
        end
        chk_modes();
        wb(1'b0, 8'h10, 32'h0, 4'hf, rd); chk({8'h00, fcfg}, rd);
      end
    end
    // Software write under auto is stored until hardware changes it
    wb(1'b1, 8'h10, 32'h00c3c0, 4'h7, rd);
    fcfg = 24'h00c3c0;
    wb(1'b0, 8'h10, 32'h0, 4'hf, rd); chk({8'h00, fcfg}, rd);
    chk_modes();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
